// ===== pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             ref_clk_i,   // system clock
   input  wire logic             sys_rst_i,   // synchronous reset, high
   input  wire logic [WIDTH-1:0] async_i,     // raw pin levels
   input  wire logic [WIDTH-1:0] rst_val_i,   // level held during reset
   output logic      [WIDTH-1:0] sync_o       // synchronised levels
);

   logic [1:0][WIDTH-1:0] sync_reg;
   logic [1:0][WIDTH-1:0] sync_next;

   // first stage feeds only the second stage
   always_comb begin
      sync_next[0] = async_i;
      sync_next[1] = sync_reg[0];
   end

   // state register, reset loads the idle pin levels of both stages
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sync_reg <= {rst_val_i, rst_val_i};
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg[1];

endmodule
`default_nettype wire

// ===== spi_master_model.sv
// partner model: serial bus master driving clock, select and data
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
   input  wire logic clk_i,    // pacing clock
   input  wire logic cpol_i,   // clock idle level
   input  wire logic miso_i,   // data from the slave
   output wire logic sck_o,    // serial clock
   output logic      mosi_o,   // data to the slave
   output logic      ss_n_o    // select, low active
);
   logic ph;

   // clock stands at its idle level outside frames
   assign sck_o = ph ^ cpol_i;

   initial begin
      ph     = 1'b0;
      mosi_o = 1'b0;
      ss_n_o = 1'b1; // idle high
   end

   // one shared select; data line goes to the inverse once released
   task automatic sel(input logic lvl);
      repeat (8) @(posedge clk_i);
      ss_n_o <= lvl;
      if (lvl) mosi_o <= ~mosi_o;
      repeat (8) @(posedge clk_i);
   endtask

   // msb first, 400 ns bit time; slave bit taken just before active-to-idle
   task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         mosi_o <= tx[i];
         repeat (4) @(posedge clk_i);
         ph <= 1'b1;
         repeat (4) @(posedge clk_i);
         rx = {rx[6:0], miso_i};
         ph <= 1'b0;
      end
   endtask
endmodule

`default_nettype wire

// ===== spi_slave_cfg.svh
// constants for the serial port slave: offsets, fields, modes, timing
`ifndef SPI_SLAVE_CFG_SVH
`define SPI_SLAVE_CFG_SVH

// register byte addresses
`define ADR_DATA_BUFFER   8'h00
`define ADR_CONTROL_ONE   8'h04
`define ADR_CONTROL_THREE 8'h08
`define ADR_STATUS        8'h0C
`define ADR_IRQ_CONTROL   8'h10

// serial_control_one fields
`define C1_WRITE_COLLISION_FLAG   7
`define C1_OV     6
`define C1_EN     5
`define C1_CKP    4
`define C1_MODE_HI 3
// serial_control_three fields
`define C3_BUFFER_OVERWRITE_ENABLE   4
// serial_status fields
`define ST_SMP    7
`define ST_CKE    6
`define ST_BF     0
// irq control fields
`define IQ_FLAG   0
`define IQ_ENABLE 1

// mode field codes
`define MODE_SLAVE_SS   4'h4
`define MODE_SLAVE_NOSS 4'h5
`define MODE_MASTER_TOP 4'h3

// reset values and counter limits
`define RST_BYTE  8'h00
`define RST_MODE  4'h0
`define BIT_LAST  3'h7
`define BIT_ZERO  3'h0
`define TGL_END   5'h10

// timing: system clock period and master half bit time in ns
`define CLK_NS         50
`define MASTER_HALF_NS 200
`define MASTER_HALF_CYC ((`MASTER_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== spi_slave_pkg.sv
// types shared by the serial port slave design
package spi_slave_pkg;

   // synchronised pin levels
   typedef struct packed {
      logic sck;
      logic sdi;
      logic ss_n;
   } pins_type;

   // whole state of the port
   typedef struct packed {
      logic        wb_ack;
      logic [31:0] wb_dat;
      logic [7:0]  buf_data;
      logic [7:0]  shifter;
      logic [2:0]  bit_cnt;
      logic        sdo_bit;
      logic        sdo_drive;
      logic        sck_prev;
      logic        write_collision_flag;
      logic        ov;
      logic        en;
      logic        clock_idle_polarity;
      logic [3:0]  mode;
      logic        buffer_overwrite_enable;
      logic        input_sample_phase;
      logic        cke;
      logic        bf;
      logic        flag;
      logic        int_en;
      logic        wake;
      logic        m_active;
      logic        m_sck;
      logic [4:0]  m_tgl;
      logic [7:0]  div_cnt;
   } port_state_type;

endpackage

// ===== spi_slave_port.sv
// serial peripheral port slave with select sync and wishbone registers
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_cfg.svh"

module spi_slave_port
   import spi_slave_pkg::*;
(
   input  wire logic        ref_clk_i,       // system clock, 20 MHz
   input  wire logic        sys_rst_i,       // synchronous reset, high
   input  wire logic        wb_cyc_i,        // wishbone cycle
   input  wire logic        wb_stb_i,        // wishbone strobe
   input  wire logic        wb_we_i,         // wishbone write
   input  wire logic [7:0]  wb_adr_i,        // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,        // wishbone byte enables
   input  wire logic [31:0] wb_dat_i,        // wishbone write data
   output logic      [31:0] wb_dat_o,        // wishbone read data
   output logic             wb_ack_o,        // wishbone acknowledge
   input  wire logic        serial_clock_pin_i,   // clock pin level
   output logic             serial_clock_pin_o,   // clock driven in master mode
   output logic             serial_clock_pin_oe_n_o, // low while clock driven
   input  wire logic        serial_data_in_pin_i, // data in pin
   output logic             serial_data_out_pin_o, // data out level
   output logic             serial_data_out_pin_oe_n_o, // low while driven
   input  wire logic        slave_select_n_i,     // slave select, low active
   input  wire logic        sleep_i,              // device asleep
   output logic             port_interrupt_flag_o, // flag level
   output logic             wake_o                // wake request
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation

   pins_type pins;
   pins_type pins_rst;

   assign pins_rst = '{sck: 1'b0, sdi: 1'b0, ss_n: 1'b1};

   // pins cross through two flops before any use
   pin_sync #(
      .WIDTH(3)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({serial_clock_pin_i, serial_data_in_pin_i, slave_select_n_i}),
      .rst_val_i (pins_rst),
      .sync_o    (pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   port_state_type st_reg;
   port_state_type st_next;

   // master modes are the low mode codes
   function automatic logic is_master(input logic [3:0] m);
      return m <= `MODE_MASTER_TOP;
   endfunction

   logic sck_now;
   logic active_lvl;
   logic lead_edge;
   logic trail_edge;
   logic sample_edge;
   logic out_edge;
   logic master;
   logic ss_ctl;
   logic deselect;
   logic selected;
   logic bus_req;
   logic wr_lane;
   logic busy;

   assign master      = is_master(st_reg.mode);
   assign ss_ctl      = (st_reg.mode == `MODE_SLAVE_SS);
   // the slave clock comes from the pin only
   assign sck_now     = master ? st_reg.m_sck : pins.sck;
   assign active_lvl  = sck_now != st_reg.clock_idle_polarity;
   assign lead_edge   = (sck_now != st_reg.sck_prev) && active_lvl;
   assign trail_edge  = (sck_now != st_reg.sck_prev) && !active_lvl;
   assign sample_edge = st_reg.cke ? lead_edge : trail_edge;
   assign out_edge    = st_reg.cke ? trail_edge : lead_edge;
   assign deselect    = ss_ctl && pins.ss_n;
   assign selected    = st_reg.en && (master ? st_reg.m_active
                        : (ss_ctl ? !pins.ss_n : st_reg.mode == `MODE_SLAVE_NOSS));
   assign bus_req     = wb_cyc_i && wb_stb_i && !st_reg.wb_ack;
   assign wr_lane     = bus_req && wb_we_i && wb_sel_i[0];
   assign busy        = (st_reg.bit_cnt != `BIT_ZERO) || st_reg.m_active;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [7:0] rx;
      rx = {st_reg.shifter[6:0], pins.sdi};
      st_next = st_reg;
      st_next.wb_ack = bus_req;
      st_next.sck_prev = sck_now;

      // register reads, buffer read clears full flag
      st_next.wb_dat = '0;
      if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            `ADR_DATA_BUFFER: begin
               st_next.wb_dat[7:0] = st_reg.buf_data;
               st_next.bf = 1'b0;
            end
            `ADR_CONTROL_ONE: begin
               st_next.wb_dat[7:0] = {st_reg.write_collision_flag, st_reg.ov, st_reg.en,
                                      st_reg.clock_idle_polarity, st_reg.mode};
            end
            `ADR_CONTROL_THREE: begin
               st_next.wb_dat[`C3_BUFFER_OVERWRITE_ENABLE] = st_reg.buffer_overwrite_enable;
            end
            `ADR_STATUS: begin
               st_next.wb_dat[`ST_SMP] = st_reg.input_sample_phase;
               st_next.wb_dat[`ST_CKE] = st_reg.cke;
               st_next.wb_dat[`ST_BF]  = st_reg.bf;
            end
            `ADR_IRQ_CONTROL: begin
               st_next.wb_dat[`IQ_FLAG]   = st_reg.flag;
               st_next.wb_dat[`IQ_ENABLE] = st_reg.int_en;
            end
            default: begin
               st_next.wb_dat = '0;
            end
         endcase
      end

      // register writes, hardware sets below win over these clears
      if (wr_lane) begin
         case (wb_adr_i)
            `ADR_DATA_BUFFER: begin
               if (busy) begin
                  st_next.write_collision_flag = 1'b1;
               end else if (!st_reg.bf || st_reg.buffer_overwrite_enable) begin
                  st_next.buf_data = wb_dat_i[7:0];
                  st_next.shifter  = wb_dat_i[7:0];
                  st_next.sdo_bit  = wb_dat_i[7];
                  if (master && st_reg.en) begin
                     st_next.m_active = 1'b1;
                     st_next.m_tgl    = '0;
                     st_next.div_cnt  = '0;
                  end
               end
            end
            `ADR_CONTROL_ONE: begin
               st_next.write_collision_flag = wb_dat_i[`C1_WRITE_COLLISION_FLAG];
               st_next.ov   = wb_dat_i[`C1_OV];
               st_next.en   = wb_dat_i[`C1_EN];
               st_next.clock_idle_polarity  = wb_dat_i[`C1_CKP];
               st_next.mode = wb_dat_i[`C1_MODE_HI:0];
               st_next.m_sck = wb_dat_i[`C1_CKP];
            end
            `ADR_CONTROL_THREE: begin
               st_next.buffer_overwrite_enable = wb_dat_i[`C3_BUFFER_OVERWRITE_ENABLE];
            end
            `ADR_STATUS: begin
               st_next.input_sample_phase = wb_dat_i[`ST_SMP];
               st_next.cke = wb_dat_i[`ST_CKE];
            end
            `ADR_IRQ_CONTROL: begin
               st_next.flag   = st_reg.flag && wb_dat_i[`IQ_FLAG];
               st_next.int_en = wb_dat_i[`IQ_ENABLE];
            end
            default: begin
               st_next.buffer_overwrite_enable = st_reg.buffer_overwrite_enable;
            end
         endcase
      end

      // master clock divider, stopped while asleep
      if (st_reg.en && master && st_reg.m_active && !sleep_i) begin
         if (st_reg.div_cnt == 8'(`MASTER_HALF_CYC - 1)) begin
            st_next.div_cnt = '0;
            st_next.m_sck   = !st_reg.m_sck;
            st_next.m_tgl   = st_reg.m_tgl + 5'h01;
            if (st_reg.m_tgl == `TGL_END - 5'h01) begin
               st_next.m_active = 1'b0;
            end
         end else begin
            st_next.div_cnt = st_reg.div_cnt + 8'h01;
         end
      end

      // shifting, output follows the out edge
      if (selected) begin
         st_next.sdo_drive = 1'b1;
         if (out_edge) begin
            st_next.sdo_bit = st_reg.shifter[7];
         end
         if (sample_edge) begin
            st_next.shifter = rx;
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            if (st_reg.bit_cnt == `BIT_LAST) begin
               st_next.flag = 1'b1;
               if (st_reg.bf && !st_reg.buffer_overwrite_enable) begin
                  st_next.ov = 1'b1;
               end else begin
                  st_next.buf_data = rx;
                  st_next.bf = 1'b1;
               end
            end
         end
      end

      // deselect or disable floats output and realigns
      if (!st_reg.en || (!master && deselect)) begin
         st_next.sdo_drive = 1'b0;
         st_next.bit_cnt   = `BIT_ZERO;
      end
      if (!st_reg.en) begin
         st_next.bit_cnt  = `BIT_ZERO;
         st_next.m_active = 1'b0;
         st_next.sdo_drive = 1'b0;
      end
      if (!master && !ss_ctl && st_reg.mode != `MODE_SLAVE_NOSS) begin
         st_next.sdo_drive = 1'b0;
      end

      // wake request while asleep
      st_next.wake = sleep_i && st_next.flag && st_next.int_en;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o                   = st_reg.wb_dat;
   assign wb_ack_o                   = st_reg.wb_ack;
   assign serial_clock_pin_o         = st_reg.m_sck;
   assign serial_clock_pin_oe_n_o    = !(st_reg.en && master);
   assign serial_data_out_pin_o      = st_reg.sdo_bit;
   assign serial_data_out_pin_oe_n_o = !st_reg.sdo_drive;
   assign port_interrupt_flag_o      = st_reg.flag;
   assign wake_o                     = st_reg.wake;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_last_bit;
      selected && sample_edge && st_reg.bit_cnt == `BIT_LAST;
   endsequence

   sequence s_flag_set;
      port_interrupt_flag_o && (st_reg.bf || st_reg.ov);
   endsequence

   a_ack_one_shot: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over two cycles");
   a_ack_after_req: assert property (bus_req |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_byte_flag_set: assert property (s_last_bit |=> s_flag_set)
      else $error("flag not set after eighth bit");
   a_deselect_float: assert property (st_reg.en && ss_ctl && pins.ss_n
      |=> serial_data_out_pin_oe_n_o && st_reg.bit_cnt == `BIT_ZERO)
      else $error("output still driven after deselect");
   a_disable_clears: assert property (!st_reg.en |=> st_reg.bit_cnt == `BIT_ZERO)
      else $error("counter not cleared when disabled");
   a_wake_in_sleep: assert property (sleep_i && st_next.flag && st_next.int_en
      |=> wake_o)
      else $error("no wake while asleep");
   a_master_freeze: assert property (master && st_reg.m_active && sleep_i
      |=> $stable(st_reg.m_sck) && $stable(st_reg.div_cnt))
      else $error("master moved while asleep");
   a_collision_flag: assert property (wr_lane && wb_adr_i == `ADR_DATA_BUFFER && busy
      |=> st_reg.write_collision_flag && wb_ack_o)
      else $error("collision not flagged");
   a_msb_first: assert property (selected && sample_edge && st_reg.bit_cnt != `BIT_ZERO
      |=> st_reg.shifter[7:1] == $past(st_reg.shifter[6:0])
          && st_reg.shifter[0] == $past(pins.sdi))
      else $error("shift order wrong");

endmodule
`default_nettype wire

// ===== spi_slave_port_with_select_sync_tb_top.sv
// testbench: wishbone tasks, serial frames, reference model of the buffer
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_cfg.svh"

module spi_slave_port_with_select_sync_tb_top;
   logic        clk, rst, cyc, stb, we, sleep, cpol, sdo_last, sck_held;
   logic [3:0]  wsel;
   logic        bf_m, ov_m, buffer_overwrite_enable_m, ie_m;
   logic [7:0]  adr, rx, lf, sh_m, buf_m;
   logic [31:0] wdat, rdat;
   wire  [31:0] dat_o;
   wire         ack, sck, mosi, ss_n, sck_out, sck_oe_n, sdo, sdo_oe_n, flag, wake, miso;
   int          n_fail, tests_run;

   spi_slave_port spi_slave_port_i (
      .ref_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .serial_clock_pin_i(sck),
      .serial_clock_pin_o(sck_out), .serial_clock_pin_oe_n_o(sck_oe_n),
      .serial_data_in_pin_i(mosi), .serial_data_out_pin_o(sdo),
      .serial_data_out_pin_oe_n_o(sdo_oe_n), .slave_select_n_i(ss_n),
      .sleep_i(sleep), .port_interrupt_flag_o(flag), .wake_o(wake));

   spi_master_model spi_master_model_i (
      .clk_i(clk), .cpol_i(cpol), .miso_i(miso), .sck_o(sck), .mosi_o(mosi), .ss_n_o(ss_n));

   // released data out shows the inverse of its last driven level
   assign miso = sdo_oe_n ? ~sdo_last : sdo;
   always @(posedge clk) if (sdo_oe_n === 1'b0) sdo_last <= sdo;

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [7:0] nx(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
      int k;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= dt;
      for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk);
      if (k == 20) begin
         n_fail++;
         $display("[FAIL] bus ack expected 1 seen none");
         stop_test();
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wbuf;
      lf = nx(lf);
      wb(1'b1, `ADR_DATA_BUFFER, {24'h0, lf});
      if (!bf_m || buffer_overwrite_enable_m) sh_m = lf;
   endtask

   task automatic rbuf;
      wb(1'b0, `ADR_DATA_BUFFER, 32'h0);
      chk("buffer", rdat, {24'h0, buf_m});
      bf_m = 1'b0;
   endtask

   task automatic regs;
      wb(1'b0, `ADR_STATUS, 32'h0);
      chk("status", rdat, {24'h0, 7'h20, bf_m});
      wb(1'b0, `ADR_CONTROL_ONE, 32'h0);
      chk("control one", rdat, {24'h0, 1'b0, ov_m, 6'h24});
   endtask

   // one whole byte under select, flag cleared first
   task automatic frame;
      wb(1'b1, `ADR_IRQ_CONTROL, {30'h0, ie_m, 1'b0});
      lf = nx(lf);
      spi_master_model_i.sel(1'b0);
      spi_master_model_i.bits(lf, 8, rx);
      chk("sdo driven", sdo_oe_n, 1'b0);
      spi_master_model_i.sel(1'b1);
      chk("sdo floats", sdo_oe_n, 1'b1);
      chk("clock not driven", sck_oe_n, 1'b1);
      chk("miso byte", rx, sh_m);
      chk("flag", flag, 1'b1);
      chk("wake", wake, sleep & ie_m);
      sh_m = lf;
      if (bf_m && !buffer_overwrite_enable_m) ov_m = 1'b1;
      else begin
         buf_m = lf;
         bf_m  = 1'b1;
      end
   endtask

   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      wsel = 4'hF;
      adr = 8'h00;
      wdat = 32'h0;
      sleep = 1'b0;
      cpol = 1'b0;
      sdo_last = 1'b0;
      lf = 8'h14;
      {sh_m, buf_m, bf_m, ov_m, buffer_overwrite_enable_m, ie_m} = '0;
      n_fail = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      chk("sdo float at reset", sdo_oe_n, 1'b1);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", rdat, 32'h0);
      // slave with select, edge select set, clock idle low
      wb(1'b1, `ADR_STATUS, 32'h40);
      wb(1'b1, `ADR_CONTROL_ONE, 32'h24);
      regs();
      // exchange, chained resend, overflow, blocked and forced writes
      wbuf();
      frame();
      regs();
      rbuf();
      frame();
      frame();
      regs();
      rbuf();
      wb(1'b1, `ADR_CONTROL_ONE, 32'h24);
      ov_m = 1'b0;
      frame();
      wbuf();
      wb(1'b1, `ADR_CONTROL_THREE, 32'h10);
      buffer_overwrite_enable_m = 1'b1;
      // write without the low byte lane is acked but ignored
      wsel <= 4'hE;
      wb(1'b1, `ADR_CONTROL_THREE, 32'h0);
      wsel <= 4'hF;
      wb(1'b0, `ADR_CONTROL_THREE, 32'h0);
      chk("control three", rdat, 32'h10);
      wbuf();
      frame();
      rbuf();
      // mid-byte collision then select realign; mid-byte disable
      for (int k = 0; k < 2; k++) begin
         spi_master_model_i.sel(1'b0);
         spi_master_model_i.bits(8'hA5, 3, rx);
         if (k == 0) begin
            wb(1'b1, `ADR_DATA_BUFFER, 32'h3C);
            wb(1'b0, `ADR_CONTROL_ONE, 32'h0);
            chk("collision", rdat[7], 1'b1);
            spi_master_model_i.sel(1'b1);
            spi_master_model_i.sel(1'b0);
         end else begin
            wb(1'b1, `ADR_CONTROL_ONE, 32'h04);
            wb(1'b1, `ADR_CONTROL_ONE, 32'h24);
         end
         lf = nx(lf);
         spi_master_model_i.bits(lf, 8, rx);
         spi_master_model_i.sel(1'b1);
         buf_m = lf;
         sh_m = lf;
         rbuf();
      end
      // clock idle high, byte received asleep wakes the device
      wb(1'b1, `ADR_CONTROL_ONE, 32'h04);
      cpol <= 1'b1;
      wb(1'b1, `ADR_CONTROL_ONE, 32'h34);
      ie_m = 1'b1;
      wbuf();
      sleep <= 1'b1;
      frame();
      sleep <= 1'b0;
      rbuf();
      // master mode: clock driven, frozen while asleep, resumes after
      wb(1'b1, `ADR_IRQ_CONTROL, 32'h0);
      wb(1'b1, `ADR_CONTROL_ONE, 32'h20);
      chk("clock driven", sck_oe_n, 1'b0);
      wbuf();
      repeat (20) @(posedge clk);
      sleep <= 1'b1;
      repeat (2) @(posedge clk);
      sck_held = sck_out;
      repeat (12) begin
         @(posedge clk);
         chk("clock frozen", sck_out, sck_held);
      end
      chk("no byte asleep", flag, 1'b0);
      sleep <= 1'b0;
      repeat (80) @(posedge clk);
      chk("master byte done", flag, 1'b1);
      chk("clock back idle", sck_out, 1'b0);
      buf_m = {8{mosi}};
      bf_m  = 1'b1;
      rbuf();
      stop_test();
   end
endmodule

`default_nettype wire
